/* File: core/pbo_regs.svh */
// Constants for the processor bus ownership state machine
`ifndef PBO_REGS_SVH
`define PBO_REGS_SVH

// Transfers in one burst-inhibited line transfer, counted as one bus cycle
`define PBO_LINE_BEATS 4
`define PBO_BEAT_W 2
`define PBO_LAST_BEAT 2'h3
`define PBO_FIRST_BEAT 2'h0

// Flip-flops on every pin input before logic reads it
`define PBO_SYNC_STAGES 2

// Pin inputs gathered into one synchroniser word
`define PBO_PIN_W 5
`define PBO_PIN_GRANT 0
`define PBO_PIN_HELD 1
`define PBO_PIN_ACK 2
`define PBO_PIN_ERR 3
`define PBO_PIN_ALT_TS 4

// Reset level of the synchroniser: every pin input reads negated (high)
`define PBO_PIN_RESET 5'h1f

`endif

/* File: core/pbo_pkg.sv */
// Types for the processor bus ownership state machine
`include "pbo_regs.svh"
package pbo_pkg;

	typedef enum logic [2:0] {
		PBO_IDLE,
		PBO_SNOOP,
		PBO_IMPLICIT,
		PBO_PARK,
		PBO_ACTIVE
	} pbo_state_e;

	typedef logic [`PBO_BEAT_W-1:0] pbo_beat_t;

endpackage : pbo_pkg

/* File: core/pbo_sync.sv */
// Two-stage synchroniser for a word of independent pin levels
module pbo_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// Each bit crosses alone; the first stage feeds only the second
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				meta_ff[i] <= RESET_VAL[i];
				sync_ff[i] <= RESET_VAL[i];
			end else begin
				meta_ff[i] <= pin_in[i];
				sync_ff[i] <= meta_ff[i];
			end
		end
	end

	assign sync_out = sync_ff;

endmodule : pbo_sync

/* File: core/pbo_fsm.sv */
// Processor-side bus ownership state machine: request, hold, park, release
//
// Overview of operation
// - Granted with nothing pending: implicit ownership, bus undefined, bus_held not driven.
// - Request in implicit ownership asserts held, request, in-progress and start together.
// - Grant still present at cycle end with nothing pending: park, keep bus_held, drive undefined values.
// - Leave park with request, in-progress, start; return to park after cycle.
// - Exactly one of idle, snoop, implicit, park, active at any time.
// - Idle (except its one release clock) and snoop drive nothing, bus_held negated; snoop serves observed transfers.
// - Alternate master owns bus while snooping: bus_held not driven, bus undriven.
// - Active cycle asserts bus_held and in-progress, bus carries defined values.
// - Release guaranteed only if grant drops before the final acknowledge edge.
// - Request may be withdrawn unused, granted or not.
// - Withdrawn request may return at once or stay negated indefinitely.
// - Grant seen with bus_held negated: assert bus_held and start next clock.
// - Releasing: drive held and in-progress negated, then three-state everything.
// - Request negated when the last cycle begins from idle with nothing else pending.
// - Retry with grant negated: release bus, request again next clock.
// - Request pin is a registered copy of the internal request.
// - All state changes on the rising bus clock edge.
// - Request pin always actively driven, never wired-OR.
// - Four-transfer line counts as one cycle; bus kept until fourth completes.
`include "pbo_regs.svh"
module pbo_fsm (
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Internal access side
	input wire logic acc_req_in,
	input wire logic acc_line_in,
	output logic acc_taken_out,
	output logic acc_done_out,
	output logic acc_error_out,
	output logic acc_retry_out,
	// Arbitration and bus pins, active low except the active-high enables and bus_defined_out
	input wire logic ownership_grant_b_in,
	input wire logic bus_held_b_in,
	input wire logic transfer_ack_b_in,
	input wire logic transfer_error_ack_b_in,
	input wire logic alt_transfer_start_b_in,
	output logic ownership_request_b_out,
	output logic bus_held_b_out,
	output logic bus_held_oe_out,
	output logic transfer_in_progress_b_out,
	output logic transfer_in_progress_oe_out,
	output logic transfer_start_b_out,
	output logic bus_oe_out,
	output logic bus_defined_out,
	// Status
	output logic snoop_ready_out,
	output pbo_pkg::pbo_state_e state_out
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [`PBO_PIN_W-1:0] pin_raw;
	logic [`PBO_PIN_W-1:0] pin_sync;

	assign pin_raw[`PBO_PIN_GRANT] = ownership_grant_b_in;
	assign pin_raw[`PBO_PIN_HELD] = bus_held_b_in;
	assign pin_raw[`PBO_PIN_ACK] = transfer_ack_b_in;
	assign pin_raw[`PBO_PIN_ERR] = transfer_error_ack_b_in;
	assign pin_raw[`PBO_PIN_ALT_TS] = alt_transfer_start_b_in;

	pbo_sync #(
		.WIDTH(`PBO_PIN_W),
		.RESET_VAL(`PBO_PIN_RESET)
	) u_pin_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.pin_in(pin_raw),
		.sync_out(pin_sync)
	);

	logic grant;
	logic held_seen;
	logic ack;
	logic err;
	logic alt_start;

	// Pins are active low; internal terms are active high
	assign grant = !pin_sync[`PBO_PIN_GRANT];
	assign held_seen = !pin_sync[`PBO_PIN_HELD];
	assign ack = !pin_sync[`PBO_PIN_ACK];
	assign err = !pin_sync[`PBO_PIN_ERR];
	assign alt_start = !pin_sync[`PBO_PIN_ALT_TS];

	////////////////////////////////////////////////////////////////////////
	// Pin drive pattern per state

	// Returns {held_oe, held_b, tip_oe, tip_b, bus_oe, defined}
	function automatic logic [5:0] pin_drive(
		input pbo_pkg::pbo_state_e st,
		input logic releasing
	);
		logic [5:0] d;
		d = 6'h14;
		case (st)
			pbo_pkg::PBO_ACTIVE: begin
				d = 6'h2b;
			end
			pbo_pkg::PBO_PARK: begin
				d = 6'h2e;
			end
			pbo_pkg::PBO_IMPLICIT: begin
				d = 6'h1e;
			end
			pbo_pkg::PBO_IDLE: begin
				// Negated levels for one clock, then let go of everything
				d = releasing ? 6'h3e : 6'h14;
			end
			pbo_pkg::PBO_SNOOP: begin
				d = 6'h14;
			end
			default: begin
				d = 6'h14;
			end
		endcase
		return d;
	endfunction : pin_drive

	////////////////////////////////////////////////////////////////////////
	// State and cycle tracking

	pbo_pkg::pbo_state_e state_ff;
	pbo_pkg::pbo_state_e nxt_state;
	pbo_pkg::pbo_beat_t beat_ff;
	pbo_pkg::pbo_beat_t nxt_beat;
	logic line_ff;
	logic nxt_line;
	logic retry_ff;
	logic nxt_retry;
	logic release_ff;
	logic nxt_release;
	logic start_ff;
	logic nxt_start;
	logic req_b_ff;
	logic nxt_req_b;
	logic taken_ff;
	logic nxt_taken;
	logic done_ff;
	logic nxt_done;
	logic error_ff;
	logic nxt_error;
	logic rty_ff;
	logic nxt_rty;

	logic pending;
	logic final_ack;
	logic begin_cycle;
	logic owned_start;

	// A retried access outranks a new one and is pending until rerun
	assign pending = acc_req_in || retry_ff;
	// Error ends the cycle at once; a line waits for its last beat
	assign final_ack = (state_ff == pbo_pkg::PBO_ACTIVE) && !start_ff
		&& (err || (ack && (!line_ff || beat_ff == `PBO_LAST_BEAT)));

	always_comb begin
		nxt_state = state_ff;
		nxt_beat = beat_ff;
		nxt_line = line_ff;
		nxt_retry = retry_ff;
		nxt_release = 1'b0;
		begin_cycle = 1'b0;
		owned_start = 1'b0;
		nxt_done = 1'b0;
		nxt_error = 1'b0;
		nxt_rty = 1'b0;
		case (state_ff)
			pbo_pkg::PBO_IDLE: begin
				if (grant && !held_seen) begin
					if (pending) begin
						nxt_state = pbo_pkg::PBO_ACTIVE;
						begin_cycle = 1'b1;
					end else begin
						nxt_state = pbo_pkg::PBO_IMPLICIT;
					end
				end else if (held_seen && alt_start) begin
					nxt_state = pbo_pkg::PBO_SNOOP;
				end
			end
			pbo_pkg::PBO_SNOOP: begin
				if (!held_seen) begin
					nxt_state = pbo_pkg::PBO_IDLE;
				end
			end
			pbo_pkg::PBO_IMPLICIT: begin
				if (pending) begin
					nxt_state = pbo_pkg::PBO_ACTIVE;
					begin_cycle = 1'b1;
					owned_start = 1'b1;
				end else if (!grant) begin
					nxt_state = pbo_pkg::PBO_IDLE;
				end
			end
			pbo_pkg::PBO_PARK: begin
				if (pending) begin
					nxt_state = pbo_pkg::PBO_ACTIVE;
					begin_cycle = 1'b1;
					owned_start = 1'b1;
				end else if (!grant) begin
					nxt_state = pbo_pkg::PBO_IDLE;
					nxt_release = 1'b1;
				end
			end
			pbo_pkg::PBO_ACTIVE: begin
				if (ack && !err && !start_ff) begin
					nxt_beat = pbo_pkg::pbo_beat_t'(beat_ff + 1'b1);
				end
				if (final_ack) begin
					nxt_done = 1'b1;
					nxt_error = err && !ack;
					nxt_rty = err && ack;
					nxt_retry = err && ack;
					// Grant sampled at the final acknowledge edge decides
					if (!grant) begin
						nxt_state = pbo_pkg::PBO_IDLE;
						nxt_release = 1'b1;
					end else if (acc_req_in || (err && ack)) begin
						// Back-to-back cycle while still granted
						begin_cycle = 1'b1;
					end else begin
						nxt_state = pbo_pkg::PBO_PARK;
					end
				end
			end
			default: begin
				nxt_state = pbo_pkg::PBO_IDLE;
			end
		endcase
		if (begin_cycle) begin
			nxt_beat = `PBO_FIRST_BEAT;
			// A retry keeps its own line flag
			if (!retry_ff && !nxt_rty) begin
				nxt_line = acc_line_in;
			end
			nxt_retry = 1'b0;
		end
	end

	always_comb begin
		nxt_start = begin_cycle;
		nxt_taken = begin_cycle && !retry_ff && !nxt_rty;
		// Request follows the pending access, dropped once it is taken,
		// raised with the start when the bus is already owned
		nxt_req_b = !((pending && !begin_cycle) || owned_start || nxt_rty);
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_ff <= pbo_pkg::PBO_IDLE;
			beat_ff <= `PBO_FIRST_BEAT;
			line_ff <= 1'b0;
			retry_ff <= 1'b0;
			release_ff <= 1'b0;
			start_ff <= 1'b0;
			req_b_ff <= 1'b1;
			taken_ff <= 1'b0;
			done_ff <= 1'b0;
			error_ff <= 1'b0;
			rty_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			beat_ff <= nxt_beat;
			line_ff <= nxt_line;
			retry_ff <= nxt_retry;
			release_ff <= nxt_release;
			start_ff <= nxt_start;
			req_b_ff <= nxt_req_b;
			taken_ff <= nxt_taken;
			done_ff <= nxt_done;
			error_ff <= nxt_error;
			rty_ff <= nxt_rty;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered pin outputs

	logic [5:0] nxt_drive;
	logic [5:0] drive_ff;
	logic nxt_ts_b;
	logic ts_b_ff;
	logic nxt_snoop;
	logic snoop_ff;

	always_comb begin
		nxt_drive = pin_drive(nxt_state, nxt_release);
		nxt_ts_b = !nxt_start;
		nxt_snoop = (nxt_state == pbo_pkg::PBO_SNOOP);
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			drive_ff <= 6'h14;
			ts_b_ff <= 1'b1;
			snoop_ff <= 1'b0;
		end else begin
			drive_ff <= nxt_drive;
			ts_b_ff <= nxt_ts_b;
			snoop_ff <= nxt_snoop;
		end
	end

	assign bus_held_oe_out = drive_ff[5];
	assign bus_held_b_out = drive_ff[4];
	assign transfer_in_progress_oe_out = drive_ff[3];
	assign transfer_in_progress_b_out = drive_ff[2];
	assign bus_oe_out = drive_ff[1];
	assign bus_defined_out = drive_ff[0];
	assign transfer_start_b_out = ts_b_ff;
	// Point-to-point pin, driven in every state
	assign ownership_request_b_out = req_b_ff;
	assign acc_taken_out = taken_ff;
	assign acc_done_out = done_ff;
	assign acc_error_out = error_ff;
	assign acc_retry_out = rty_ff;
	assign snoop_ready_out = snoop_ff;
	assign state_out = state_ff;

endmodule : pbo_fsm

/* File: testbench/pbo_fsm_checker.sv */
// Port-level assertions for the bus ownership state machine
module pbo_fsm_checker (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic acc_req_in,
	input wire logic acc_taken_out,
	input wire logic acc_retry_out,
	input wire logic ownership_request_b_out,
	input wire logic bus_held_b_out,
	input wire logic bus_held_oe_out,
	input wire logic transfer_in_progress_b_out,
	input wire logic transfer_start_b_out,
	input wire logic bus_oe_out,
	input wire logic bus_defined_out,
	input wire logic snoop_ready_out,
	input wire pbo_pkg::pbo_state_e state_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	////////////////////////////////////////////////////////////////
	a_start_once:
	assert property (!transfer_start_b_out |=> transfer_start_b_out)
		else $error("start pulse too long");
	a_start_drive:
	assert property (!transfer_start_b_out |-> bus_held_oe_out && !bus_held_b_out
		&& !transfer_in_progress_b_out && bus_defined_out)
		else $error("start without ownership drive");
	a_taken_start:
	assert property (acc_taken_out |-> !transfer_start_b_out)
		else $error("taken without start");
	a_release_neg:
	assert property ($fell(bus_held_oe_out) |-> $past(bus_held_b_out))
		else $error("held released while asserted");
	a_idle_quiet:
	assert property (state_out == pbo_pkg::PBO_IDLE && $past(state_out) == pbo_pkg::PBO_IDLE
		|-> !bus_oe_out && !bus_held_oe_out)
		else $error("idle drives bus");
	a_implicit_own:
	assert property (state_out == pbo_pkg::PBO_IMPLICIT
		|-> !bus_held_oe_out && bus_oe_out && !bus_defined_out)
		else $error("implicit drive wrong");
	a_park_drive:
	assert property (state_out == pbo_pkg::PBO_PARK |-> bus_held_oe_out && !bus_held_b_out
		&& transfer_in_progress_b_out && bus_oe_out && !bus_defined_out)
		else $error("park drive wrong");
	a_park_start:
	assert property ($past(state_out) == pbo_pkg::PBO_PARK && !transfer_start_b_out
		|-> !ownership_request_b_out)
		else $error("park exit without request");
	a_snoop_quiet:
	assert property (snoop_ready_out
		|-> state_out == pbo_pkg::PBO_SNOOP && !bus_held_oe_out && !bus_oe_out)
		else $error("snoop drives bus");
	a_req_cause:
	assert property ($fell(ownership_request_b_out) |-> $past(acc_req_in) || acc_retry_out)
		else $error("request without access");
endmodule : pbo_fsm_checker

/* File: testbench/pbo_arb_model.sv */
// External arbiter, target and alternate master facing the state machine
module pbo_arb_model (
	input wire logic clk_in,
	input wire logic grant_in,
	input wire logic alt_in,
	input wire logic [1:0] end_in,
	input wire logic line_in,
	input wire logic transfer_start_b_in,
	output logic ownership_grant_b_out,
	output logic alt_held_b_out,
	output logic alt_held_oe_out,
	output logic alt_transfer_start_b_out,
	output logic transfer_ack_b_out,
	output logic transfer_error_ack_b_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic alt_q = 1'b0;
	logic [2:0] cnt = 3'h0;
	initial begin
		{ownership_grant_b_out, alt_held_b_out, alt_transfer_start_b_out} = 3'h7;
		{transfer_ack_b_out, transfer_error_ack_b_out, alt_held_oe_out} = 3'h6;
	end
	////////////////////////////////////////////////////////////////
	// Grant never waits on held, avoiding lockup
	always @(posedge clk_in) begin
		ownership_grant_b_out <= !grant_in;
		alt_q <= alt_in;
		// Alternate tenure opens only while the grant is off
		alt_transfer_start_b_out <= !(alt_in && !alt_q && !grant_in);
		alt_held_b_out <= !alt_in;
		alt_held_oe_out <= alt_in || alt_q;
		transfer_ack_b_out <= 1'b1;
		transfer_error_ack_b_out <= 1'b1;
		if (!transfer_start_b_in) begin
			cnt <= line_in ? 3'h6 : 3'h3;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
			if (cnt <= (line_in ? 3'h4 : 3'h1)) begin
				transfer_ack_b_out <= end_in == 2'h1;
				transfer_error_ack_b_out <= end_in == 2'h0;
			end
		end
	end
endmodule : pbo_arb_model

/* File: testbench/test_processor_bus_ownership_fsm.sv */
// Self-checking bench for the bus ownership state machine
module test_processor_bus_ownership_fsm;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic req = 1'b0;
	logic line = 1'b0;
	logic grant = 1'b0;
	logic alt = 1'b0;
	logic [1:0] end_sel = 2'h0;
	logic taken, done, err, retry, req_b, held_b, held_oe, tip_b, tip_oe, ts_b, bus_oe, defd;
	logic snoop, grant_b, alt_held_b, alt_held_oe, alt_ts_b, ack_b, err_b, held_lvl;
	pbo_pkg::pbo_state_e st;
	int mismatches = 0;
	int num_checks = 0;
	int n1;
	int n2;
	always #25 clk_in = ~clk_in;
	// Pull-up on held: low only while someone drives it low
	assign held_lvl = !((held_oe && !held_b) || (alt_held_oe && !alt_held_b));
	pbo_fsm dut_u (.clk_in, .rst_b_in, .acc_req_in(req), .acc_line_in(line),
		.acc_taken_out(taken), .acc_done_out(done), .acc_error_out(err), .acc_retry_out(retry),
		.ownership_grant_b_in(grant_b), .bus_held_b_in(held_lvl), .transfer_ack_b_in(ack_b),
		.transfer_error_ack_b_in(err_b), .alt_transfer_start_b_in(alt_ts_b),
		.ownership_request_b_out(req_b), .bus_held_b_out(held_b), .bus_held_oe_out(held_oe),
		.transfer_in_progress_b_out(tip_b), .transfer_in_progress_oe_out(tip_oe),
		.transfer_start_b_out(ts_b), .bus_oe_out(bus_oe), .bus_defined_out(defd),
		.snoop_ready_out(snoop), .state_out(st));
	pbo_arb_model arb_u (.clk_in, .grant_in(grant), .alt_in(alt), .end_in(end_sel),
		.line_in(line), .transfer_start_b_in(ts_b), .ownership_grant_b_out(grant_b),
		.alt_held_b_out(alt_held_b), .alt_held_oe_out(alt_held_oe),
		.alt_transfer_start_b_out(alt_ts_b), .transfer_ack_b_out(ack_b),
		.transfer_error_ack_b_out(err_b));
	////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc
	// Bounded wait for start (sel 0) or completion (sel 1)
	task wt(input bit sel, output int n);
		n = 0;
		while ((sel ? done : !ts_b) !== 1'b1 && n < 40) begin
			@(negedge clk_in);
			n++;
		end
		chk(n < 40, 1'b1);
	endtask : wt
	task results;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////
	task t_withdraw;
		req = 1'b1;
		cyc(1);
		chk(req_b, 1'b0);
		req = 1'b0;
		cyc(1);
		chk(req_b, 1'b1);
		req = 1'b1;
		cyc(1);
		chk(req_b, 1'b0);
		req = 1'b0;
		cyc(3);
		chk({req_b, held_oe, bus_oe}, 3'h4);
	endtask : t_withdraw
	task t_release;
		grant = 1'b1;
		req = 1'b1;
		wt(0, n1);
		req = 1'b0;
		grant = 1'b0;
		chk({held_b, tip_b, defd}, 3'h1);
		cyc(1);
		chk(req_b, 1'b1);
		wt(1, n1);
		cyc(3);
		chk({st, held_oe, bus_oe}, {pbo_pkg::PBO_IDLE, 2'h0});
	endtask : t_release
	// Grant dropped early: the whole line still completes first
	task t_line;
		line = 1'b1;
		grant = 1'b1;
		req = 1'b1;
		wt(0, n2);
		req = 1'b0;
		grant = 1'b0;
		cyc(1);
		wt(1, n2);
		chk(n2, n1 + 3);
		chk(held_oe, 1'b1);
		line = 1'b0;
		cyc(3);
	endtask : t_line
	task t_own;
		// Grant held across the whole park/active run, never broken mid-sequence
		grant = 1'b1;
		cyc(4);
		chk({st, held_oe, bus_oe, defd}, {pbo_pkg::PBO_IMPLICIT, 3'h2});
		req = 1'b1;
		wt(0, n2);
		req = 1'b0;
		chk({held_b, req_b, tip_b}, 3'h0);
		wt(1, n2);
		cyc(2);
		chk({st, held_oe, held_b, bus_oe, defd}, {pbo_pkg::PBO_PARK, 4'ha});
		req = 1'b1;
		wt(0, n2);
		req = 1'b0;
		chk({req_b, tip_b}, 2'h0);
		wt(1, n2);
		cyc(2);
		chk({st, req_b, tip_b}, {pbo_pkg::PBO_PARK, 2'h3});
		grant = 1'b0;
		cyc(4);
		chk(st, pbo_pkg::PBO_IDLE);
		chk(held_lvl, 1'b1);
	endtask : t_own
	task t_retry;
		grant = 1'b1;
		req = 1'b1;
		wt(0, n2);
		req = 1'b0;
		grant = 1'b0;
		end_sel = 2'h2;
		wt(1, n2);
		chk(retry, 1'b1);
		cyc(1);
		chk(req_b, 1'b0);
		cyc(2);
		chk({held_oe, bus_oe}, 2'h0);
		end_sel = 2'h1;
		grant = 1'b1;
		wt(0, n2);
		grant = 1'b0;
		wt(1, n2);
		chk(err, 1'b1);
		end_sel = 2'h0;
		cyc(4);
	endtask : t_retry
	task t_snoop;
		alt = 1'b1;
		cyc(5);
		chk({st, snoop, held_oe, bus_oe}, {pbo_pkg::PBO_SNOOP, 3'h4});
		alt = 1'b0;
		cyc(5);
		chk({st, snoop}, {pbo_pkg::PBO_IDLE, 1'b0});
	endtask : t_snoop
	////////////////////////////////////////////////////////////////
	initial begin
		cyc(20);
		rst_b_in = 1'b1;
		cyc(3);
		chk({st, req_b, held_oe, tip_oe, bus_oe, ts_b}, {pbo_pkg::PBO_IDLE, 5'h11});
		t_withdraw();
		t_release();
		t_line();
		t_own();
		t_retry();
		t_snoop();
		results();
	end
	// All scenarios take well under 1000 cycles
	initial begin
		#1000000;
		mismatches++;
		results();
	end
endmodule : test_processor_bus_ownership_fsm

bind pbo_fsm pbo_fsm_checker chk_u (.clk_in, .rst_b_in, .acc_req_in, .acc_taken_out,
	.acc_retry_out, .ownership_request_b_out, .bus_held_b_out, .bus_held_oe_out,
	.transfer_in_progress_b_out, .transfer_start_b_out, .bus_oe_out, .bus_defined_out,
	.snoop_ready_out, .state_out);
